// ==== hw/iwdt_pkg.sv ====
// What this block does
// - Index port selects a register; the port above it reads or writes it.
// - Two successive key bytes on the index port unlock; locked accesses are ignored.
// - Writing 08 to index 07 selects the watchdog register set.
// - Writing 01 to index 30 enables the watchdog; disabled after reset.
// - Bit 3 of index F5 picks seconds (0, default) or minutes (1).
// - Index F6 holds the timeout count; 0 stops, 01..FF give 1..255 units.
// - Any write to the count register reloads and restarts the counter.
// - Expiry without reload raises the timeout action.
// - A static strap chooses reset output or interrupt line 11.
// - Timeout interrupt is active low and stays low until the timer is reset.
// - Bit 4 of index F7 reads 1 once the watchdog has timed out.
// - Writing 1 to bit 5 of index F7 forces timeout; bit reads back 0.
// - Lock byte on the index port relocks until the next key pair.
package iwdt_pkg;
   // Port decode
   localparam logic [15:0] INDEX_PORT  = 16'h002e;
   localparam logic [15:0] DATA_PORT   = 16'h002f;
   localparam logic [7:0]  KEY_BYTE    = 8'h87;
   localparam logic [7:0]  LOCK_BYTE   = 8'haa;
   // Register indexes and values
   localparam logic [7:0]  REG_LDN     = 8'h07;
   localparam logic [7:0]  LDN_WDT     = 8'h08;
   localparam logic [7:0]  REG_ACT     = 8'h30;
   localparam logic [7:0]  ACT_ON      = 8'h01;
   localparam logic [7:0]  REG_UNIT    = 8'hf5;
   localparam int          UNIT_BIT    = 3;
   localparam logic [7:0]  REG_COUNT   = 8'hf6;
   localparam logic [7:0]  COUNT_RST   = 8'h00;
   localparam logic [7:0]  REG_CTRL    = 8'hf7;
   localparam int          STAT_BIT    = 4;
   localparam int          FORCE_BIT   = 5;
   localparam logic [7:0]  IDLE_READ   = 8'hff;
   // Interrupt line number served by the low-active output
   localparam int          IRQ_LINE    = 11;
   // Strap level that routes the action to the interrupt
   localparam logic        STRAP_IRQ   = 1'b0;
   // Timing
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          SEC_NS        = 1000000000;
   localparam int          SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
   localparam int          SEC_PER_MIN   = 60;

   typedef struct packed {
      logic       keySeen;
      logic       unlocked;
      logic [7:0] index;
      logic [7:0] ldn;
      logic       active;
      logic       unitMin;
      logic [7:0] count;
      logic       expired;
      logic [7:0] rdData;
      logic       irqN;
      logic       rstOut;
   } iwdt_state_s;
endpackage

// ==== hw/iwdt_tick_if.sv ====
`timescale 1ns/1ps
interface iwdt_tick_if;
   logic restart;
   logic secTick;
   logic minTick;
   modport gen (input restart, output secTick, output minTick);
   modport user (output restart, input secTick, input minTick);
endinterface

// ==== hw/iwdt_tick_gen.sv ====
`timescale 1ns/1ps
module iwdt_tick_gen #(
   parameter int CYCLES_PER_SEC = iwdt_pkg::SEC_CYCLES,
   parameter int SEC_PER_MIN    = iwdt_pkg::SEC_PER_MIN
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Ticks towards the counter
   iwdt_tick_if.gen tick
);
   localparam int CW = $clog2(CYCLES_PER_SEC);
   localparam int MW = $clog2(SEC_PER_MIN);

   typedef struct packed {
      logic [CW-1:0] cyc;
      logic [MW-1:0] sec;
      logic          secTick;
      logic          minTick;
   } iwdt_tick_s;

   iwdt_tick_s st_r;
   iwdt_tick_s st_nxt;

   initial begin
      if (CYCLES_PER_SEC < 2 || SEC_PER_MIN < 2) begin
         $error("iwdt_tick_gen: prescale counts must be at least 2");
      end
   end

   // Prescaler chain; restart realigns both ticks to the reload
   always_comb begin
      st_nxt = st_r;
      st_nxt.secTick = 1'b0;
      st_nxt.minTick = 1'b0;
      if (tick.restart) begin
         st_nxt.cyc = '0;
         st_nxt.sec = '0;
      end else if (st_r.cyc == CW'(CYCLES_PER_SEC - 1)) begin
         st_nxt.cyc = '0;
         st_nxt.secTick = 1'b1;
         if (st_r.sec == MW'(SEC_PER_MIN - 1)) begin
            st_nxt.sec = '0;
            st_nxt.minTick = 1'b1;
         end else begin
            st_nxt.sec = st_r.sec + MW'(1);
         end
      end else begin
         st_nxt.cyc = st_r.cyc + CW'(1);
      end
   end

   // State register
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick.secTick = st_r.secTick;
   assign tick.minTick = st_r.minTick;
endmodule

// ==== hw/iwdt_watchdog.sv ====
`timescale 1ns/1ps
module iwdt_watchdog #(
   parameter int CYCLES_PER_SEC = iwdt_pkg::SEC_CYCLES,
   parameter int SEC_PER_MIN    = iwdt_pkg::SEC_PER_MIN
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // Host I/O cycles
   input  wire logic [15:0] ioAddr,
   input  wire logic        ioWr,
   input  wire logic        ioRd,
   input  wire logic [7:0]  ioWrData,
   output logic      [7:0]  ioRdData,
   // Board strap
   input  wire logic        timeoutActionStrap,
   // Timeout action
   output logic             wdtIrqN,
   output logic             wdtResetOut
);
   iwdt_pkg::iwdt_state_s st_r;
   iwdt_pkg::iwdt_state_s st_nxt;
   iwdt_tick_if           tick ();

   logic wrIdx;
   logic wrDat;
   logic rdDat;
   logic wdtSel;
   logic unitTick;
   logic countWrite;
   logic ctrlForce;

   iwdt_tick_gen #(
      .CYCLES_PER_SEC (CYCLES_PER_SEC),
      .SEC_PER_MIN    (SEC_PER_MIN)
   ) u_tick (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .tick    (tick)
   );

   // Port decode and qualified accesses
   assign wrIdx      = ioWr && (ioAddr == iwdt_pkg::INDEX_PORT);
   assign wrDat      = ioWr && (ioAddr == iwdt_pkg::DATA_PORT) && st_r.unlocked;
   assign rdDat      = ioRd && (ioAddr == iwdt_pkg::DATA_PORT);
   assign wdtSel     = (st_r.ldn == iwdt_pkg::LDN_WDT);
   assign unitTick   = st_r.unitMin ? tick.minTick : tick.secTick;
   assign countWrite = wrDat && wdtSel && (st_r.index == iwdt_pkg::REG_COUNT);
   assign ctrlForce  = wrDat && wdtSel && (st_r.index == iwdt_pkg::REG_CTRL) && ioWrData[iwdt_pkg::FORCE_BIT];
   assign tick.restart = countWrite;

   // Next state: unlock, index, registers, countdown, action
   always_comb begin
      st_nxt = st_r;
      // Index port: key pair, lock byte, register select
      if (wrIdx) begin
         if (!st_r.unlocked) begin
            st_nxt.keySeen  = (ioWrData == iwdt_pkg::KEY_BYTE);
            st_nxt.unlocked = st_r.keySeen && (ioWrData == iwdt_pkg::KEY_BYTE);
         end else if (ioWrData == iwdt_pkg::LOCK_BYTE) begin
            st_nxt.unlocked = 1'b0;
            st_nxt.keySeen  = 1'b0;
         end else begin
            st_nxt.index = ioWrData;
         end
      end
      // Countdown once per selected tick; frozen at zero or once expired
      if (st_r.active && !st_r.expired && st_r.count != 8'h00 && unitTick) begin
         st_nxt.count = st_r.count - 8'h01;
         if (st_r.count == 8'h01) begin
            st_nxt.expired = 1'b1;
         end
      end
      // Data port writes
      if (wrDat) begin
         if (st_r.index == iwdt_pkg::REG_LDN) begin
            st_nxt.ldn = ioWrData;
         end else if (wdtSel) begin
            case (st_r.index)
               iwdt_pkg::REG_ACT:   st_nxt.active = (ioWrData == iwdt_pkg::ACT_ON);
               iwdt_pkg::REG_UNIT:  st_nxt.unitMin = ioWrData[iwdt_pkg::UNIT_BIT];
               iwdt_pkg::REG_COUNT: begin
                  st_nxt.count   = ioWrData;
                  st_nxt.expired = 1'b0;
               end
               default: ;
            endcase
         end
      end
      // Forced timeout wins over a reload in the same cycle
      if (ctrlForce) begin
         st_nxt.expired = 1'b1;
      end
      // Data port reads; locked or unmapped reads float high
      if (rdDat) begin
         st_nxt.rdData = iwdt_pkg::IDLE_READ;
         if (st_r.unlocked) begin
            if (st_r.index == iwdt_pkg::REG_LDN) begin
               st_nxt.rdData = st_r.ldn;
            end else if (wdtSel) begin
               case (st_r.index)
                  iwdt_pkg::REG_ACT:   st_nxt.rdData = {7'h00, st_r.active};
                  iwdt_pkg::REG_UNIT:  st_nxt.rdData = 8'(st_r.unitMin) << iwdt_pkg::UNIT_BIT;
                  iwdt_pkg::REG_COUNT: st_nxt.rdData = st_r.count;
                  iwdt_pkg::REG_CTRL:  st_nxt.rdData = 8'(st_r.expired) << iwdt_pkg::STAT_BIT;
                  default:             st_nxt.rdData = iwdt_pkg::IDLE_READ;
               endcase
            end
         end
      end
      // Action routed by the strap, registered with the flag
      st_nxt.irqN   = !(st_nxt.expired && timeoutActionStrap == iwdt_pkg::STRAP_IRQ);
      st_nxt.rstOut = st_nxt.expired && timeoutActionStrap != iwdt_pkg::STRAP_IRQ;
   end

   // State register
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '{keySeen: 1'b0, unlocked: 1'b0, index: 8'h00, ldn: 8'h00, active: 1'b0,
                   unitMin: 1'b0, count: iwdt_pkg::COUNT_RST, expired: 1'b0, rdData: 8'h00,
                   irqN: 1'b1, rstOut: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign ioRdData    = st_r.rdData;
   assign wdtIrqN     = st_r.irqN;
   assign wdtResetOut = st_r.rstOut;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   // Key byte on the index port while the first key is held
   sequence sKeyPair;
      !st_r.unlocked && st_r.keySeen && wrIdx && ioWrData == iwdt_pkg::KEY_BYTE;
   endsequence

   // Expiry: last count and a tick with no reload
   sequence sExpire;
      st_r.active && !st_r.expired && st_r.count == 8'h01 && unitTick && !countWrite;
   endsequence

   AST_UNLOCK: assert property (sKeyPair |=> st_r.unlocked)
      else $error("Key pair did not unlock");
   AST_LOCKED_IGNORE: assert property (!st_r.unlocked && ioWr && ioAddr == iwdt_pkg::DATA_PORT
      |=> $stable(st_r.ldn) && $stable(st_r.active) && $stable(st_r.unitMin))
      else $error("Locked data write changed a register");
   AST_LOCK: assert property (st_r.unlocked && wrIdx && ioWrData == iwdt_pkg::LOCK_BYTE
      |=> !st_r.unlocked ##1 !st_r.unlocked || st_r.keySeen)
      else $error("Lock byte did not lock");
   AST_LDN: assert property (wrDat && st_r.index == iwdt_pkg::REG_LDN |=> st_r.ldn == $past(ioWrData))
      else $error("Device select not stored");
   AST_ACTIVATE: assert property (wrDat && wdtSel && st_r.index == iwdt_pkg::REG_ACT
      |=> st_r.active == ($past(ioWrData) == iwdt_pkg::ACT_ON))
      else $error("Activation write mishandled");
   AST_UNIT: assert property (wrDat && wdtSel && st_r.index == iwdt_pkg::REG_UNIT
      |=> st_r.unitMin == $past(ioWrData[iwdt_pkg::UNIT_BIT]))
      else $error("Unit bit not stored");
   AST_RELOAD: assert property (countWrite && !ctrlForce
      |=> st_r.count == $past(ioWrData) && !st_r.expired ##1 st_r.irqN && !st_r.rstOut)
      else $error("Count write did not reload and clear the action");
   AST_EXPIRE: assert property (sExpire and !ctrlForce
      |=> st_r.expired && st_r.count == 8'h00 && (st_r.irqN == st_r.rstOut))
      else $error("Expiry did not raise the action");
   AST_HOLD: assert property (st_r.expired && !countWrite
      |=> st_r.expired && (st_r.count == 8'h00 || $past(st_r.count) == st_r.count))
      else $error("Expired state not held");
   AST_STEP: assert property (st_r.active && st_r.count != 8'h00 && !unitTick && !wrDat
      |=> $stable(st_r.count))
      else $error("Counter moved without a tick");
   AST_STATUS: assert property (rdDat && st_r.unlocked && wdtSel && st_r.index == iwdt_pkg::REG_CTRL
      |=> ioRdData[iwdt_pkg::STAT_BIT] == $past(st_r.expired) && !ioRdData[iwdt_pkg::FORCE_BIT])
      else $error("Status bit read wrong");
   AST_FORCE: assert property (ctrlForce |=> st_r.expired ##1 (st_r.irqN == 1'b0 || st_r.rstOut))
      else $error("Forced timeout not raised");
endmodule

// ==== verification/iwdt_host_model.sv ====
`timescale 1ns/1ps
module iwdt_host_model (
   // Clock
   input  wire logic        sys_clk,
   // Host I/O cycles
   output logic      [15:0] ioAddr,
   output logic             ioWr,
   output logic             ioRd,
   output logic      [7:0]  ioWrData,
   // Read answer
   input  wire logic [7:0]  ioRdData
);
   // Idle bus at time zero
   initial begin
      ioAddr   = 16'h0000;
      ioWr     = 1'b0;
      ioRd     = 1'b0;
      ioWrData = 8'h00;
   end
   // One I/O cycle, launched on a falling edge, taken at the next rising edge
   task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] d);
      @(negedge sys_clk);
      ioAddr   = a;
      ioWr     = w;
      ioRd     = ~w;
      ioWrData = d;
      @(negedge sys_clk);
      ioWr     = 1'b0;
      ioRd     = 1'b0;
      ioAddr   = ~a; // Released lines lose the old value
      ioWrData = ~d;
   endtask
   // Register write, index first
   task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
      cyc(iwdt_pkg::INDEX_PORT, 1'b1, idx);
      cyc(iwdt_pkg::DATA_PORT, 1'b1, d);
   endtask
   // Register read, index first, answer taken a cycle later
   task automatic rreg(input logic [7:0] idx, output logic [7:0] d);
      cyc(iwdt_pkg::INDEX_PORT, 1'b1, idx);
      cyc(iwdt_pkg::DATA_PORT, 1'b0, 8'h00);
      @(negedge sys_clk);
      d = ioRdData;
   endtask
   // Key pair opens configuration
   task automatic unlock();
      cyc(iwdt_pkg::INDEX_PORT, 1'b1, iwdt_pkg::KEY_BYTE);
      cyc(iwdt_pkg::INDEX_PORT, 1'b1, iwdt_pkg::KEY_BYTE);
   endtask
   // Lock byte closes configuration
   task automatic lock();
      cyc(iwdt_pkg::INDEX_PORT, 1'b1, iwdt_pkg::LOCK_BYTE);
   endtask
endmodule

// ==== verification/indexed_port_watchdog_timer_tb_top.sv ====
`timescale 1ns/1ps
module indexed_port_watchdog_timer_tb_top;
   localparam int CPS = 10;
   localparam int SPM = 3;
   logic        sys_clk = 1'b0;
   logic        resetn  = 1'b0;
   logic        strap   = 1'b0;
   logic [15:0] ioAddr;
   logic        ioWr;
   logic        ioRd;
   logic [7:0]  ioWrData;
   logic [7:0]  ioRdData;
   logic        wdtIrqN;
   logic        wdtResetOut;
   logic [7:0]  d;
   int          err_total = 0;
   int          samples_checked = 0;
   // Clock
   always #5 sys_clk = ~sys_clk;
   iwdt_host_model host (.sys_clk(sys_clk), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
                         .ioWrData(ioWrData), .ioRdData(ioRdData));
   iwdt_watchdog #(.CYCLES_PER_SEC(CPS), .SEC_PER_MIN(SPM)) dut (
      .sys_clk(sys_clk), .resetn(resetn), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
      .ioWrData(ioWrData), .ioRdData(ioRdData), .timeoutActionStrap(strap),
      .wdtIrqN(wdtIrqN), .wdtResetOut(wdtResetOut));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic pass(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   function automatic logic [7:0] act();
      return {6'h00, wdtResetOut, wdtIrqN};
   endfunction
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Reset with the given strap level
   task automatic do_reset(input logic s);
      @(negedge sys_clk);
      resetn = 1'b0;
      strap  = s;
      pass(5);
      check(act(), 8'h01);
      check(ioRdData, 8'h00);
      resetn = 1'b1;
   endtask
   // Locked accesses, key pairing, register set select, disabled default
   task automatic t_lock();
      host.wreg(iwdt_pkg::REG_LDN, iwdt_pkg::LDN_WDT);
      host.rreg(iwdt_pkg::REG_LDN, d);
      check(d, iwdt_pkg::IDLE_READ);
      host.cyc(iwdt_pkg::INDEX_PORT, 1'b1, iwdt_pkg::KEY_BYTE);
      host.cyc(iwdt_pkg::INDEX_PORT, 1'b1, 8'h00);
      host.cyc(iwdt_pkg::INDEX_PORT, 1'b1, iwdt_pkg::KEY_BYTE);
      host.rreg(iwdt_pkg::REG_LDN, d);
      check(d, iwdt_pkg::IDLE_READ);
      host.unlock();
      host.wreg(iwdt_pkg::REG_LDN, iwdt_pkg::LDN_WDT);
      host.rreg(iwdt_pkg::REG_LDN, d);
      check(d, iwdt_pkg::LDN_WDT);
      host.wreg(iwdt_pkg::REG_COUNT, 8'h01);
      pass(2 * CPS);
      check(act(), 8'h01);
   endtask
   // Seconds timeout, servicing, hold, status, stop, disable
   task automatic t_expire();
      host.wreg(iwdt_pkg::REG_ACT, iwdt_pkg::ACT_ON);
      host.wreg(iwdt_pkg::REG_UNIT, 8'h00);
      host.wreg(iwdt_pkg::REG_COUNT, 8'h03);
      pass(3 * CPS - 3);
      check(act(), 8'h01);
      host.wreg(iwdt_pkg::REG_COUNT, 8'h03);
      pass(3 * CPS - 3);
      check(act(), 8'h01);
      pass(5);
      check(act(), 8'h00);
      host.rreg(iwdt_pkg::REG_CTRL, d);
      check(d, 8'h10);
      pass(4 * CPS);
      check(act(), 8'h00);
      host.wreg(iwdt_pkg::REG_COUNT, 8'h00);
      pass(2);
      check(act(), 8'h01);
      pass(5 * CPS);
      check(act(), 8'h01);
      host.wreg(iwdt_pkg::REG_COUNT, 8'h02);
      host.wreg(iwdt_pkg::REG_ACT, 8'h00);
      pass(4 * CPS);
      check(act(), 8'h01);
      host.wreg(iwdt_pkg::REG_ACT, iwdt_pkg::ACT_ON);
      pass(2 * CPS + 5);
      check(act(), 8'h00);
   endtask
   // Minute unit, then relock
   task automatic t_minute();
      host.wreg(iwdt_pkg::REG_UNIT, 8'h08);
      host.rreg(iwdt_pkg::REG_UNIT, d);
      check(d, 8'h08);
      host.wreg(iwdt_pkg::REG_COUNT, 8'h01);
      pass(SPM * CPS - 5);
      check(act(), 8'h01);
      pass(8);
      check(act(), 8'h00);
      host.lock();
      host.wreg(iwdt_pkg::REG_COUNT, 8'h00);
      pass(2);
      check(act(), 8'h00);
      host.unlock();
      host.wreg(iwdt_pkg::REG_COUNT, 8'h00);
      pass(2);
      check(act(), 8'h01);
   endtask
   // Reset strap and forced timeout
   task automatic t_force();
      host.unlock();
      host.wreg(iwdt_pkg::REG_LDN, iwdt_pkg::LDN_WDT);
      host.wreg(iwdt_pkg::REG_CTRL, 8'h20);
      pass(2);
      check(act(), 8'h03);
      host.rreg(iwdt_pkg::REG_CTRL, d);
      check(d, 8'h10);
   endtask
   // Main sequence
   initial begin
      do_reset(1'b0);
      t_lock();
      t_expire();
      t_minute();
      do_reset(1'b1);
      t_force();
      final_report();
   end
   // Watchdog on the run
   initial begin
      #200000;
      err_total++;
      final_report();
   end
endmodule
